// *** verilog/sfife_pkg.sv ***
// constants for the serial flash instruction front end
package sfife_pkg;
	// instruction opcodes
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06; // write_enable_cmd
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04; // write_disable_cmd
	localparam logic [7:0] OP_ID_READ = 8'h9F; // identification_read_cmd
	localparam logic [7:0] OP_STATUS_READ = 8'h05; // status_read_cmd
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01; // status_write_cmd
	localparam logic [7:0] OP_READ = 8'h03; // plain read
	localparam logic [7:0] OP_FAST_READ = 8'h0B; // fast read
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02; // page_program_cmd
	localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8; // sector_erase_cmd
	localparam logic [7:0] OP_ARRAY_ERASE = 8'hC7; // array_erase_cmd
	localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9; // deep_sleep_cmd
	localparam logic [7:0] OP_WAKE_SIGNATURE = 8'hAB; // wake_signature_cmd
	// array organisation
	localparam int ADDR_W = 21; // linear byte address width
	localparam int SECTOR_BYTES = 65536; // bytes per sector
	localparam int PAGE_BYTES = 256; // bytes per page
	localparam int PAGE_COUNT = 8192; // pages in the array
	localparam int SECTOR_LSB = $clog2(SECTOR_BYTES); // sector field position
	localparam int PAGE_LSB = $clog2(PAGE_BYTES); // page field position
	localparam int PAGE_W = $clog2(PAGE_COUNT); // page index width
	// byte counts that frame each instruction (opcode included)
	localparam logic [3:0] CNT_OPCODE_ONLY = 4'h1;
	localparam logic [3:0] CNT_STATUS_WRITE = 4'h2;
	localparam logic [3:0] CNT_ADDR_END = 4'h4; // opcode plus three address bytes
	localparam logic [3:0] CNT_FAST_END = 4'h5; // plus one dummy byte
	localparam logic [3:0] CNT_MAX = 4'hF; // byte counter saturates here
	localparam logic [4:0] ID_LEN = 5'h14; // identification bytes, 20
	localparam logic [4:0] IDX_MAX = 5'h1F; // output index saturates here
	// identification and signature values, arbitrary except the field length
	localparam logic [7:0] ID_MAKER = 8'h5A; // arbitrary
	localparam logic [7:0] ID_TYPE = 8'h3C; // arbitrary
	localparam logic [7:0] ID_SIZE = 8'h15; // arbitrary
	localparam logic [7:0] ID_UID_LEN = 8'h10; // length of the trailing field
	localparam logic [7:0] SIGNATURE = 8'h6E; // arbitrary
	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 21'h00_0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// serial engine phases
	typedef enum logic [4:0] {
		PH_CMD = 5'b0_0001, // shifting the opcode
		PH_ARG = 5'b0_0010, // address or dummy bytes before output
		PH_OUT = 5'b0_0100, // data-out stream
		PH_DATA = 5'b0_1000, // data-in or executed on deselect
		PH_IDLE = 5'b1_0000 // ignored until deselect
	} sfife_phase_e;
endpackage

// *** verilog/sfife_sync.sv ***
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/10ps
module sfife_sync #(
	parameter int W = 4
) (
	input wire logic sys_clk_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q; // first stage, read only by the second
	// per-bit double registering
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge sys_clk_in) begin
			meta_q[i] <= async_in[i];
			sync_out[i] <= meta_q[i];
		end
	end
endmodule

// *** verilog/sfife_tx_shift.sv ***
// output byte shifter, msb first, advanced on serial clock falls
`timescale 1ns/10ps
module sfife_tx_shift (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic clear_in,
	input wire logic shift_in,
	input wire logic load_in,
	input wire logic [7:0] byte_in,
	output logic bit_out
);
	logic [6:0] rest_q; // bits still to go
	// load puts the msb on the line, otherwise shift the next bit out
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in || clear_in) begin
			rest_q <= 7'h00;
			bit_out <= 1'b0;
		end else if (shift_in && load_in) begin
			bit_out <= byte_in[7];
			rest_q <= byte_in[6:0];
		end else if (shift_in) begin
			bit_out <= rest_q[6];
			rest_q <= {rest_q[5:0], 1'b0};
		end
	end
endmodule

// *** verilog/sfife_core.sv ***
// serial flash instruction front end: sampling, pause, decode, latch
`timescale 1ns/10ps
// Overview of operation
// - pause stalls link only, internal cycles continue
// - pause starts on hold fall with clock low
// - pause ends on hold rise with clock low
// - paused: output off, clock and data ignored
// - deselect during pause resets serial logic
// - linear address, 32 sectors, 8192 pages
// - program clears bits, erase by sector or whole array
// - all bytes travel msb first
// - data sampled on rising clock after select
// - opcode first, then address or data bytes
// - deselect during output ends instruction cleanly
// - modifying instructions need byte-aligned deselect
// - array access ignored while cycle busy
// - decode plain and fast read opcodes
// - decode status read, id read, status write
// - decode page program, sector and array erase
// - decode deep sleep and wake with signature
// - write enable opcode sets the latch
// - write disable opcode clears the latch
// - latch cleared at reset and modifying completions
// - latch clear refuses modifying instructions
module sfife_core import sfife_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic din_in,
	input wire logic hold_n_in,
	input wire logic cycle_busy_flag_in,
	input wire logic [7:0] status_bits_in,
	input wire logic [7:0] array_data_in,
	output logic q_out,
	output logic q_oe_out,
	output logic paused_out,
	output logic write_enable_latch_out,
	output logic deep_sleep_out,
	output logic [ADDR_W-1:0] array_addr_out,
	output logic [PAGE_W-1:0] page_index_out,
	output logic [4:0] sector_index_out,
	output logic status_write_out,
	output logic [7:0] status_data_out,
	output logic page_program_out,
	output logic sector_erase_out,
	output logic array_erase_out,
	output logic prog_data_valid_out,
	output logic [7:0] prog_data_out,
	output logic cmd_rejected_out
);
	logic [3:0] pin_s; // synchronised pins
	logic sclk_p_q; // previous serial clock level
	logic cs_n_p_q; // previous chip select level
	logic pause_q, pause_d; // hold condition
	sfife_phase_e phase_q, phase_d; // serial engine phase
	logic [2:0] bit_cnt_q; // bits within current byte
	logic [3:0] byte_cnt_q; // completed bytes, saturating
	logic [6:0] shift_q; // incoming bits
	logic [7:0] op_q; // latched opcode
	logic [ADDR_W-1:0] addr_q; // address register
	logic [4:0] idx_q; // output byte index
	logic load_pend_q; // next fall loads a fresh byte
	logic out_live_q; // output stream started
	logic wel_q; // write_enable_latch
	logic sleep_q; // deep sleep state
	logic [7:0] sw_data_q; // status write byte
	logic tx_bit; // shifter output

	// all four pins cross into the system clock domain
	sfife_sync #(.W(4)) u_sync (
		.sys_clk_in(sys_clk_in),
		.async_in({hold_n_in, din_in, cs_n_in, sclk_in}),
		.sync_out(pin_s)
	);
	wire sclk_s = pin_s[0];
	wire cs_n_s = pin_s[1];
	wire din_s = pin_s[2];
	wire hold_s = pin_s[3];
	wire cs_low = ~cs_n_s;

	// edge strobes; pause masks clock edges, shift state is kept
	wire sclk_rise = sclk_s & ~sclk_p_q & cs_low & ~pause_q;
	wire sclk_fall = ~sclk_s & sclk_p_q & cs_low & ~pause_q;
	wire cs_rise = cs_n_s & ~cs_n_p_q;
	wire byte_done = sclk_rise & (bit_cnt_q == 3'd7);
	wire [7:0] rx_byte = {shift_q, din_s};
	wire [3:0] cnt_next = (byte_cnt_q == CNT_MAX) ? CNT_MAX : byte_cnt_q + 4'h1;

	// pause follows the hold pin only while the clock is low
	assign pause_d = cs_low & (sclk_s ? pause_q : ~hold_s);

	// opcode classification
	wire op_arr_rd = (rx_byte == OP_READ) | (rx_byte == OP_FAST_READ)
		| (rx_byte == OP_ID_READ);
	wire op_to_arg = (rx_byte == OP_READ) | (rx_byte == OP_FAST_READ)
		| (rx_byte == OP_WAKE_SIGNATURE);
	wire op_to_out = (rx_byte == OP_STATUS_READ) | (rx_byte == OP_ID_READ);
	wire op_to_data = (rx_byte == OP_WRITE_ENABLE) | (rx_byte == OP_WRITE_DISABLE)
		| (rx_byte == OP_STATUS_WRITE) | (rx_byte == OP_PAGE_PROGRAM)
		| (rx_byte == OP_SECTOR_ERASE) | (rx_byte == OP_ARRAY_ERASE)
		| (rx_byte == OP_DEEP_SLEEP);
	wire sleep_block = sleep_q & (rx_byte != OP_WAKE_SIGNATURE);
	wire busy_block = cycle_busy_flag_in & op_arr_rd;
	// phase chosen by the opcode; unknown ones fall to idle
	wire sfife_phase_e first_ph = (sleep_block | busy_block) ? PH_IDLE
		: op_to_arg ? PH_ARG : op_to_out ? PH_OUT
		: op_to_data ? PH_DATA : PH_IDLE;
	wire [3:0] arg_end = (op_q == OP_FAST_READ) ? CNT_FAST_END : CNT_ADDR_END;

	// phase sequencing
	always_comb begin
		phase_d = phase_q;
		if (cs_n_s) begin
			phase_d = PH_CMD;
		end else if (byte_done && phase_q == PH_CMD) begin
			phase_d = first_ph;
		end else if (byte_done && phase_q == PH_ARG && cnt_next == arg_end) begin
			phase_d = PH_OUT;
		end
	end

	// byte to send next
	wire [7:0] id_byte = (idx_q == 5'd0) ? ID_MAKER : (idx_q == 5'd1) ? ID_TYPE
		: (idx_q == 5'd2) ? ID_SIZE : (idx_q == 5'd3) ? ID_UID_LEN : BYTE_RST;
	wire [7:0] tx_byte = (op_q == OP_STATUS_READ)
		? {status_bits_in[7:2], wel_q, cycle_busy_flag_in}
		: (op_q == OP_ID_READ) ? ((idx_q < ID_LEN) ? id_byte : BYTE_RST)
		: (op_q == OP_WAKE_SIGNATURE) ? SIGNATURE : array_data_in;
	wire is_array_read = (op_q == OP_READ) | (op_q == OP_FAST_READ);
	wire load_now = sclk_fall & load_pend_q;

	// execution at byte-aligned deselect, never from a paused deselect
	wire exec_ok = cs_rise & ~pause_q & (phase_q == PH_DATA)
		& (bit_cnt_q == 3'd0);
	wire wr_ok = wel_q & ~cycle_busy_flag_in;
	wire write_enable_cmd_go = exec_ok & (op_q == OP_WRITE_ENABLE) & (byte_cnt_q == CNT_OPCODE_ONLY);
	wire write_disable_cmd_go = exec_ok & (op_q == OP_WRITE_DISABLE) & (byte_cnt_q == CNT_OPCODE_ONLY);
	wire dp_go = exec_ok & (op_q == OP_DEEP_SLEEP) & (byte_cnt_q == CNT_OPCODE_ONLY);
	wire be_go = exec_ok & wr_ok & (op_q == OP_ARRAY_ERASE)
		& (byte_cnt_q == CNT_OPCODE_ONLY);
	wire status_write_cmd_go = exec_ok & wr_ok & (op_q == OP_STATUS_WRITE)
		& (byte_cnt_q == CNT_STATUS_WRITE);
	wire se_go = exec_ok & wr_ok & (op_q == OP_SECTOR_ERASE)
		& (byte_cnt_q == CNT_ADDR_END);
	wire pp_go = exec_ok & wr_ok & (op_q == OP_PAGE_PROGRAM)
		& (byte_cnt_q > CNT_ADDR_END);
	wire wake_go = cs_rise & ~pause_q & (op_q == OP_WAKE_SIGNATURE)
		& (byte_cnt_q != 4'h0) & (phase_q != PH_CMD);
	wire any_go = write_enable_cmd_go | write_disable_cmd_go | dp_go | be_go | status_write_cmd_go | se_go | pp_go;
	wire reject = cs_rise & (phase_q == PH_DATA) & ~any_go;
	// one data strobe per page program byte
	wire prog_byte = byte_done & (phase_q == PH_DATA) & (op_q == OP_PAGE_PROGRAM)
		& (byte_cnt_q >= CNT_ADDR_END) & wr_ok;

	// edge history and pause state
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			sclk_p_q <= 1'b0;
			cs_n_p_q <= 1'b1;
			pause_q <= 1'b0;
			phase_q <= PH_CMD;
		end else begin
			sclk_p_q <= sclk_s;
			cs_n_p_q <= cs_n_s;
			pause_q <= pause_d;
			phase_q <= phase_d;
		end
	end

	// bit and byte counting, opcode capture
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in || cs_n_s) begin
			bit_cnt_q <= 3'd0;
			byte_cnt_q <= 4'h0;
			shift_q <= 7'h00;
			op_q <= BYTE_RST;
		end else if (sclk_rise) begin
			bit_cnt_q <= bit_cnt_q + 3'd1;
			shift_q <= rx_byte[6:0];
			if (byte_done) begin
				byte_cnt_q <= cnt_next;
			end
			if (byte_done && phase_q == PH_CMD) begin
				op_q <= rx_byte;
			end
		end
	end

	// address gathering and read auto-increment
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			addr_q <= ADDR_RST;
		end else if (byte_done && byte_cnt_q != 4'h0 && byte_cnt_q < CNT_ADDR_END
				&& op_q != OP_WAKE_SIGNATURE) begin
			addr_q <= {addr_q[ADDR_W-9:0], rx_byte};
		end else if (load_now && is_array_read) begin
			addr_q <= addr_q + 21'h00_0001;
		end
	end

	// output stream control
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in || cs_n_s) begin
			load_pend_q <= 1'b0;
			out_live_q <= 1'b0;
			idx_q <= 5'd0;
		end else if (byte_done && phase_d == PH_OUT) begin
			load_pend_q <= 1'b1;
		end else if (load_now) begin
			load_pend_q <= 1'b0;
			out_live_q <= 1'b1;
			idx_q <= (idx_q == IDX_MAX) ? IDX_MAX : idx_q + 5'd1;
		end
	end

	// latch and deep sleep
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			wel_q <= 1'b0;
			sleep_q <= 1'b0;
		end else begin
			if (write_enable_cmd_go) begin
				wel_q <= 1'b1;
			end else if (write_disable_cmd_go | status_write_cmd_go | pp_go | se_go | be_go) begin
				wel_q <= 1'b0;
			end
			if (dp_go) begin
				sleep_q <= 1'b1;
			end else if (wake_go) begin
				sleep_q <= 1'b0;
			end
		end
	end

	// instruction pulses and captured data
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			status_write_out <= 1'b0;
			page_program_out <= 1'b0;
			sector_erase_out <= 1'b0;
			array_erase_out <= 1'b0;
			cmd_rejected_out <= 1'b0;
			prog_data_valid_out <= 1'b0;
			prog_data_out <= BYTE_RST;
			sw_data_q <= BYTE_RST;
		end else begin
			status_write_out <= status_write_cmd_go;
			page_program_out <= pp_go;
			sector_erase_out <= se_go;
			array_erase_out <= be_go;
			cmd_rejected_out <= reject;
			prog_data_valid_out <= prog_byte;
			if (prog_byte) begin
				prog_data_out <= rx_byte;
			end
			if (byte_done && op_q == OP_STATUS_WRITE && byte_cnt_q == CNT_OPCODE_ONLY) begin
				sw_data_q <= rx_byte;
			end
		end
	end

	// output bit shifter
	sfife_tx_shift u_tx (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.clear_in(cs_n_s),
		.shift_in(sclk_fall),
		.load_in(load_pend_q),
		.byte_in(tx_byte),
		.bit_out(tx_bit)
	);

	// pin drive: released when paused, deselected or not streaming
	assign q_out = tx_bit;
	assign q_oe_out = out_live_q & ~pause_q & cs_low & (phase_q == PH_OUT);
	assign paused_out = pause_q;
	assign write_enable_latch_out = wel_q;
	assign deep_sleep_out = sleep_q;
	assign status_data_out = sw_data_q;
	// ones in program data leave cells as they are; erase is sector-wide or array-wide
	assign array_addr_out = addr_q;
	assign page_index_out = addr_q[ADDR_W-1:PAGE_LSB];
	assign sector_index_out = addr_q[ADDR_W-1:SECTOR_LSB];

	// checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_fall_hi;
		cs_low && sclk_s && !hold_s && !pause_q;
	endsequence
	sequence s_clk_drop;
		cs_low && !sclk_s && !hold_s;
	endsequence
	pause_late_a: assert property (s_fall_hi ##1 s_clk_drop |=> pause_q)
		else $error("pause did not start when clock fell");
	pause_start_a: assert property (cs_low && !sclk_s && !hold_s |=> pause_q)
		else $error("pause did not start with clock low");
	pause_end_a: assert property (cs_low && !sclk_s && hold_s |=> !pause_q)
		else $error("pause did not end with clock low");
	pause_freeze_a: assert property (pause_q && cs_low |=> $stable(bit_cnt_q) && $stable(shift_q))
		else $error("shift state moved while paused");
	pause_hiz_a: assert property (pause_q |-> !q_oe_out)
		else $error("output driven while paused");
	deselect_reset_a: assert property (cs_n_s |=> !pause_q && phase_q == PH_CMD)
		else $error("deselect did not reset serial logic");
	wel_set_a: assert property (cs_rise && !pause_q && phase_q == PH_DATA
		&& op_q == OP_WRITE_ENABLE && byte_cnt_q == 4'h1 && bit_cnt_q == 3'd0
		|=> wel_q)
		else $error("write enable did not set latch");
	wel_clear_a: assert property (page_program_out || sector_erase_out
		|| array_erase_out || status_write_out |-> !wel_q)
		else $error("latch not cleared after modifying instruction");
	// the latch is judged in the cycle that accepted the instruction
	wel_gate_a: assert property ($rose(page_program_out) || $rose(sector_erase_out)
		|| $rose(array_erase_out) || $rose(status_write_out) |-> $past(wel_q))
		else $error("modifying instruction accepted with latch clear");
	align_check_a: assert property (cs_rise && bit_cnt_q != 3'd0
		|=> !page_program_out && !sector_erase_out && !status_write_out)
		else $error("unaligned instruction executed");
	busy_block_a: assert property (cycle_busy_flag_in && cs_rise |=> !page_program_out
		&& !sector_erase_out && !array_erase_out)
		else $error("instruction executed while busy");
	unknown_op_a: assert property (phase_q == PH_IDLE |-> !q_oe_out ##1 !q_oe_out)
		else $error("output driven for ignored opcode");

	// framing, refusal and sleep checks
	write_disable_cmd_clear_a: assert property (write_disable_cmd_go |=> !wel_q)
		else $error("write disable did not clear latch");
	misalign_flag_a: assert property (cs_rise && !pause_q && phase_q == PH_DATA
		&& bit_cnt_q != 3'd0 |=> cmd_rejected_out)
		else $error("unaligned instruction not rejected");
	sleep_guard_a: assert property (sleep_q && cs_rise |=> !page_program_out
		&& !sector_erase_out && !array_erase_out && !status_write_out)
		else $error("modifying instruction executed while asleep");
	prog_strobe_a: assert property (prog_data_valid_out
		|-> $past(wel_q) && !$past(cycle_busy_flag_in))
		else $error("program data passed while refused");
	busy_read_a: assert property (cycle_busy_flag_in && byte_done && phase_q == PH_CMD
		&& op_arr_rd |=> phase_q == PH_IDLE)
		else $error("array read decoded while busy");
	// only opcodes with a data-out phase may ever drive the line
	out_ops_a: assert property (q_oe_out |-> op_q == OP_READ || op_q == OP_FAST_READ
		|| op_q == OP_STATUS_READ || op_q == OP_ID_READ || op_q == OP_WAKE_SIGNATURE)
		else $error("output driven for an opcode without data out");
endmodule

// *** tb/sfife_host_model.sv ***
// spi host model driving the pins of the flash front end
`timescale 1ns/10ps
module sfife_host_model (
	input wire logic sys_clk_in,
	input wire logic q_in,
	output logic sclk_out,
	output logic cs_n_out,
	output logic din_out,
	output logic hold_n_out
);
	// idle: deselected, clock parked low, pause released
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		din_out = 1'b1;
		hold_n_out = 1'b1;
	end
	// wait a number of system clock falls, all pin changes land there
	task automatic gap(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	// select: pause is released before chip select may fall
	task automatic sel();
		gap(1);
		hold_n_out = 1'b1;
		gap(2);
		cs_n_out = 1'b0;
		gap(8);
	endtask
	// one bit: data set while clock low, answer taken at the rise
	task automatic bitx(input logic b, output logic r);
		gap(1);
		din_out = b;
		gap(7);
		sclk_out = 1'b1;
		r = q_in;
		gap(8);
		sclk_out = 1'b0;
	endtask
	// deselect after any bit; the released data line shows the inverse level
	task automatic desel();
		gap(1);
		cs_n_out = 1'b1;
		din_out = ~din_out;
		gap(12);
	endtask
	// move the pause pin, optionally with the clock standing high meanwhile
	task automatic hold_set(input logic v, input logic clk_high);
		gap(1);
		if (clk_high) begin
			sclk_out = 1'b1;
			gap(4);
		end
		// pause is only entered while the device is selected
		hold_n_out = v | cs_n_out;
		gap(8);
		if (clk_high) begin
			sclk_out = 1'b0;
			gap(8);
		end
	endtask
endmodule

// *** tb/test_serial_flash_instruction_front_end.sv ***
// self-checking bench for the serial flash instruction front end
`timescale 1ns/10ps
module test_serial_flash_instruction_front_end import sfife_pkg::*;;
	logic sys_clk_in = 1'b0; // system clock
	logic resetn_in = 1'b0; // synchronous reset
	logic busy = 1'b0; // internal cycle running
	logic [7:0] status_bits = 8'hA4; // nonvolatile status pattern
	wire sclk, cs_n, din, hold_n, q_line; // link pins
	wire q, q_oe, paused, write_enable_latch, sleep, sw, pp, se, ae, pdv, rej; // design flags
	wire [ADDR_W-1:0] addr; // array address
	wire [PAGE_W-1:0] page; // page index
	wire [4:0] sector; // sector index
	wire [7:0] sdata, pdata, adata; // status, program and array bytes
	int n_pp, n_se, n_ae, n_sw, n_rej, n_oe, fails = 0, check_count = 0, cyc = 0;
	logic [7:0] pd[$]; // program bytes seen
	logic [7:0] txq[$]; // bytes to send
	logic [7:0] rx [16]; // bytes received
	logic r; // spare received bit
	// array content is a function of the address
	assign adata = addr[7:0] ^ 8'h5C;
	// wire level: undriven output floats
	assign q_line = q_oe ? q : 1'bz;
	always #5 sys_clk_in = ~sys_clk_in;
	sfife_host_model h (.sys_clk_in(sys_clk_in), .q_in(q_line), .sclk_out(sclk),
		.cs_n_out(cs_n), .din_out(din), .hold_n_out(hold_n));
	sfife_core DUT (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .sclk_in(sclk),
		.cs_n_in(cs_n), .din_in(din), .hold_n_in(hold_n), .cycle_busy_flag_in(busy),
		.status_bits_in(status_bits), .array_data_in(adata), .q_out(q), .q_oe_out(q_oe),
		.paused_out(paused), .write_enable_latch_out(write_enable_latch), .deep_sleep_out(sleep),
		.array_addr_out(addr), .page_index_out(page), .sector_index_out(sector),
		.status_write_out(sw), .status_data_out(sdata), .page_program_out(pp),
		.sector_erase_out(se), .array_erase_out(ae), .prog_data_valid_out(pdv),
		.prog_data_out(pdata), .cmd_rejected_out(rej));
	// count one-cycle pulses and output activity, sampled where settled
	always @(negedge sys_clk_in) begin
		if (resetn_in) begin
			if (pp) n_pp++;
			if (se) n_se++;
			if (ae) n_ae++;
			if (sw) n_sw++;
			if (rej) n_rej++;
			if (q_oe) n_oe++;
			if (pdv) pd.push_back(pdata);
		end
	end
	// hang guard, well above the expected run length
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails++;
			give_verdict();
		end
	end
	// compare one value and report a mismatch
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// clear the pulse counters
	task automatic clr();
		n_pp = 0; n_se = 0; n_ae = 0; n_sw = 0; n_rej = 0; n_oe = 0;
		pd.delete();
	endtask
	// shift bits msb first, zeros past the queued bytes
	task automatic shift(input int from, input int to);
		logic rb;
		logic [7:0] b;
		for (int i = from; i < to; i++) begin
			b = (i / 8 < txq.size()) ? txq[i / 8] : 8'h00;
			h.bitx(b[7 - i % 8], rb);
			rx[i / 8][7 - i % 8] = rb;
		end
	endtask
	// one whole frame of n clock pulses
	task automatic go(input int n);
		h.sel();
		shift(0, n);
		h.desel();
	endtask
	// opcode-only frame
	task automatic cmd(input logic [7:0] op);
		txq = '{op};
		go(8);
	endtask
	// print the counts and the verdict, then stop
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		logic [7:0] idb [4];
		idb = '{ID_MAKER, ID_TYPE, ID_SIZE, ID_UID_LEN};
		repeat (8) @(negedge sys_clk_in);
		resetn_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		chk("latch at reset", 0, write_enable_latch);
		chk("oe at reset", 0, q_oe);
		cmd(OP_WRITE_ENABLE);
		chk("latch set", 1, write_enable_latch);
		cmd(OP_WRITE_DISABLE);
		chk("latch cleared", 0, write_enable_latch);
		txq = '{OP_WRITE_ENABLE};
		go(7);
		chk("short enable", 0, write_enable_latch);
		go(9);
		chk("long enable", 0, write_enable_latch);
		// program without the latch, then with it, then misaligned
		clr();
		txq = '{OP_PAGE_PROGRAM, 8'h15, 8'h43, 8'h21, 8'hF0, 8'h0F};
		go(48);
		chk("program refused", 0, n_pp);
		chk("program reject", 1, n_rej);
		cmd(OP_WRITE_ENABLE);
		clr();
		txq = '{OP_PAGE_PROGRAM, 8'h15, 8'h43, 8'h21, 8'hF0, 8'h0F};
		go(48);
		chk("program pulse", 1, n_pp);
		chk("program count", 2, pd.size());
		chk("program byte0", 8'hF0, pd[0]);
		chk("program byte1", 8'h0F, pd[1]);
		chk("page index", 13'h1543, page);
		chk("sector index", 5'h15, sector);
		chk("latch after program", 0, write_enable_latch);
		cmd(OP_WRITE_ENABLE);
		clr();
		txq = '{OP_PAGE_PROGRAM, 8'h15, 8'h43, 8'h21, 8'hF0, 8'h0F};
		go(45);
		chk("misaligned program", 0, n_pp);
		chk("misaligned reject", 1, n_rej);
		txq = '{OP_STATUS_WRITE, 8'h9C};
		go(16);
		chk("status write", 1, n_sw);
		chk("status data", 8'h9C, sdata);
		chk("latch after status", 0, write_enable_latch);
		// erases
		cmd(OP_WRITE_ENABLE);
		txq = '{OP_SECTOR_ERASE, 8'h1F, 8'h00, 8'h00};
		go(32);
		chk("sector erase", 1, n_se);
		chk("erase sector", 5'h1F, sector);
		cmd(OP_WRITE_ENABLE);
		cmd(OP_ARRAY_ERASE);
		chk("array erase", 1, n_ae);
		chk("latch after erase", 0, write_enable_latch);
		// busy: erase and read ignored, status still answers
		cmd(OP_WRITE_ENABLE);
		@(negedge sys_clk_in) busy = 1'b1;
		clr();
		cmd(OP_ARRAY_ERASE);
		chk("erase while busy", 0, n_ae);
		txq = '{OP_READ, 8'h00, 8'h00, 8'h00};
		go(48);
		chk("read while busy", 0, n_oe);
		txq = '{OP_STATUS_READ};
		go(16);
		chk("busy status", {status_bits[7:2], 2'b11}, rx[1]);
		@(negedge sys_clk_in) busy = 1'b0;
		cmd(OP_WRITE_DISABLE);
		txq = '{OP_STATUS_READ};
		go(32);
		for (int k = 1; k < 4; k++) begin
			chk("status byte", {status_bits[7:2], 2'b00}, rx[k]);
		end
		// plain and fast read across a page boundary
		for (int f = 0; f < 2; f++) begin
			if (f == 1) txq = '{OP_FAST_READ, 8'h01, 8'h02, 8'hFE, 8'h00};
			else txq = '{OP_READ, 8'h01, 8'h02, 8'hFE};
			go(8 * (txq.size() + 3));
			for (int k = 0; k < 3; k++) begin
				chk("read byte", 8'(8'hFE + k) ^ 8'h5C, rx[txq.size() + k]);
			end
		end
		txq = '{OP_ID_READ};
		go(40);
		for (int k = 0; k < 4; k++) chk("id byte", idb[k], rx[k + 1]);
		// early deselect inside output, then a clean instruction
		txq = '{OP_STATUS_READ};
		go(11);
		chk("oe after abort", 0, q_oe);
		cmd(OP_WRITE_ENABLE);
		chk("latch after abort", 1, write_enable_latch);
		cmd(OP_WRITE_DISABLE);
		clr();
		txq = '{8'hFF, OP_WRITE_ENABLE};
		go(16);
		chk("unknown output", 0, n_oe);
		chk("unknown latch", 0, write_enable_latch);
		// sleep, refused enable, wake with and without signature
		cmd(OP_DEEP_SLEEP);
		chk("asleep", 1, sleep);
		cmd(OP_WRITE_ENABLE);
		chk("enable asleep", 0, write_enable_latch);
		txq = '{OP_WAKE_SIGNATURE, 8'h00, 8'h00, 8'h00};
		go(48);
		chk("signature", SIGNATURE, rx[4]);
		chk("signature again", SIGNATURE, rx[5]);
		chk("awake", 0, sleep);
		cmd(OP_DEEP_SLEEP);
		cmd(OP_WAKE_SIGNATURE);
		chk("plain wake", 0, sleep);
		// pause with clock low in mid status byte
		txq = '{OP_STATUS_READ};
		h.sel();
		shift(0, 11);
		h.hold_set(1'b0, 1'b0);
		chk("paused", 1, paused);
		chk("oe paused", 0, q_oe);
		h.bitx(1'b1, r);
		h.bitx(1'b0, r);
		h.hold_set(1'b1, 1'b0);
		chk("resumed", 0, paused);
		shift(11, 24);
		h.desel();
		chk("status kept", {status_bits[7:2], 2'b00}, rx[1]);
		chk("status next", {status_bits[7:2], 2'b00}, rx[2]);
		// pause edges while the clock stands high
		txq = '{OP_WRITE_ENABLE};
		h.sel();
		shift(0, 8);
		fork
			h.hold_set(1'b0, 1'b1);
			begin repeat (10) @(negedge sys_clk_in); chk("wait fall", 0, paused); end
		join
		chk("paused late", 1, paused);
		fork
			h.hold_set(1'b1, 1'b1);
			begin repeat (10) @(negedge sys_clk_in); chk("still paused", 1, paused); end
		join
		chk("resumed late", 0, paused);
		h.desel();
		chk("latch odd count", 0, write_enable_latch);
		// deselect during a pause executes nothing
		h.sel();
		shift(0, 8);
		h.hold_set(1'b0, 1'b0);
		h.desel();
		chk("deselect paused", 0, write_enable_latch);
		cmd(OP_WRITE_ENABLE);
		chk("after reset latch", 1, write_enable_latch);
		chk("after reset pause", 0, paused);
		give_verdict();
	end
endmodule
